// File: src/lpm_ctrl.sv
// operating mode controller: normal, halt, sleep, peripheral stop, system stop
// assumes the core gives one-cycle instruction strobes; irq pins are async, low active
`timescale 1ns/1ps
module lpm_ctrl #(
  parameter int N_ONCHIP = lpm_pkg::N_ONCHIP
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // instruction strobes from the core, one cycle each
  input wire logic i_halt_exec,
  input wire logic i_sleep_exec,
  input wire logic [19:0] i_next_pc,
  // control state
  input wire logic i_peripheral_stop_bit,
  input wire logic [lpm_pkg::CCR_W-1:0] i_cpu_control_register,
  input wire logic i_global_irq_enable_flag,
  // interrupt sources: pins low active, on-chip high active
  input wire logic i_nmi_n,
  input wire logic i_ext_irq_zero_n,
  input wire logic i_ext_irq_one_n,
  input wire logic i_ext_irq_two_n,
  input wire logic [2:0] i_ext_irq_en,
  input wire logic [N_ONCHIP-1:0] i_onchip_irq,
  input wire logic [N_ONCHIP-1:0] i_onchip_irq_en,
  // bus grant to an external master
  input wire logic i_bus_granted,
  // mode and clock gates
  output logic [2:0] o_mode,
  output logic o_cpu_clk_en,
  output logic o_dma_clk_en,
  output logic o_periph_clk_en,
  output logic o_refresh_en,
  output logic o_clk_out_en,
  output logic o_refetch,
  // pins while low power
  output logic o_halt_indicator_n,
  output logic o_bus_status_output,
  output logic o_fetch_cycle_indicator_n,
  output logic o_force_bus_high,
  output logic [19:0] o_addr_idle,
  // resume strobes
  output logic o_resume,
  output logic o_take_irq,
  output logic [2:0] o_irq_sel,
  output logic [19:0] o_return_addr
);
  // ==========================================================
  // pin synchronisers
  logic [3:0] pin_sync;
  lpm_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_nmi_n, i_ext_irq_two_n, i_ext_irq_one_n, i_ext_irq_zero_n}),
    .o_sync(pin_sync)
  );

  logic [2:0] ext_req;
  logic nmi_req;
  logic nmi_prev_reg;
  logic nmi_edge;
  assign ext_req = ~pin_sync[2:0];
  assign nmi_req = ~pin_sync[3];
  // nmi is edge sensitive so a held low does not rewake forever
  assign nmi_edge = nmi_req & ~nmi_prev_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nmi_prev_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_req;
    end
  end

  // ==========================================================
  // wake qualification
  logic [2:0] ext_ok;
  logic [N_ONCHIP-1:0] chip_ok;
  logic wake_halt;
  logic wake_sleep;
  logic wake_sstop;
  lpm_pkg::lpm_mode_t mode_reg;
  lpm_pkg::lpm_mode_t mode_next;

  // one enable gate per external pin
  for (genvar g = 0; g < lpm_pkg::N_EXT; g++) begin : g_ext
    assign ext_ok[g] = ext_req[g] & i_ext_irq_en[g];
  end
  assign chip_ok = i_onchip_irq & i_onchip_irq_en;
  assign wake_halt = nmi_edge | (|ext_ok) | (|chip_ok);
  assign wake_sleep = nmi_edge | (|ext_ok) | (|chip_ok);
  // on-chip sources are frozen by the stop bit, so only pins wake system stop
  assign wake_sstop = nmi_edge | (|ext_ok);

  // priority: nmi, then ext 0,1,2, then any on-chip source as one code, 4
  function automatic logic [2:0] pick_src(input logic [2:0] e, input logic [N_ONCHIP-1:0] c,
                                          input logic n);
    logic [2:0] s;
    s = 3'h7;
    if (n) begin
      s = 3'h3;
    end else if (e[0]) begin
      s = 3'h0;
    end else if (e[1]) begin
      s = 3'h1;
    end else if (e[2]) begin
      s = 3'h2;
    end else if (|c) begin
      s = 3'h4;
    end
    return s;
  endfunction

  // ==========================================================
  // mode state
  logic sleep_ok;
  logic [1:0] wake_cnt_reg;
  logic wake_irq_reg;
  logic [2:0] wake_src_reg;
  logic wake_from_sstop;
  // last count of the restart delay
  localparam logic [1:0] RESTART_LAST = lpm_pkg::RESTART_CYC_W - 2'h1;

  // sleep only when the stop bit and ccr bits are clear
  assign sleep_ok = ~i_peripheral_stop_bit & ~i_cpu_control_register[lpm_pkg::CCR_BIT_A]
                    & ~i_cpu_control_register[lpm_pkg::CCR_BIT_B];
  assign wake_from_sstop = (mode_reg == lpm_pkg::LPM_SSTOP) & wake_sstop;

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      lpm_pkg::LPM_NORMAL: begin
        if (i_halt_exec) begin
          mode_next = lpm_pkg::LPM_HALT;
        end else if (i_sleep_exec && sleep_ok) begin
          mode_next = lpm_pkg::LPM_SLEEP;
        end else if (i_sleep_exec && i_peripheral_stop_bit) begin
          mode_next = lpm_pkg::LPM_SSTOP;
        end
      end
      lpm_pkg::LPM_HALT: begin
        if (wake_halt) begin
          mode_next = lpm_pkg::LPM_NORMAL;
        end
      end
      lpm_pkg::LPM_SLEEP: begin
        if (wake_sleep) begin
          mode_next = lpm_pkg::LPM_WAKE;
        end
      end
      lpm_pkg::LPM_SSTOP: begin
        if (wake_sstop) begin
          mode_next = lpm_pkg::LPM_WAKE;
        end
      end
      lpm_pkg::LPM_WAKE: begin
        if (wake_cnt_reg == RESTART_LAST) begin
          mode_next = lpm_pkg::LPM_NORMAL;
        end
      end
      default: begin
        mode_next = lpm_pkg::LPM_NORMAL;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_reg <= lpm_pkg::LPM_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // restart delay: 1.5 clocks rounds up to two
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_cnt_reg <= 2'h0;
    end else if (mode_reg == lpm_pkg::LPM_WAKE) begin
      wake_cnt_reg <= wake_cnt_reg + 2'h1;
    end else begin
      wake_cnt_reg <= 2'h0;
    end
  end

  // ==========================================================
  // latch the wake cause and return address
  logic [19:0] ret_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ret_reg <= 20'h00000;
    end else if (i_halt_exec || i_sleep_exec) begin
      ret_reg <= i_next_pc;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_irq_reg <= 1'b0;
      wake_src_reg <= 3'h7;
    end else if ((mode_reg == lpm_pkg::LPM_SLEEP && wake_sleep) || wake_from_sstop) begin
      // nmi is taken regardless; maskable only with the global enable
      wake_irq_reg <= nmi_edge | i_global_irq_enable_flag;
      wake_src_reg <= pick_src(ext_ok, wake_from_sstop ? '0 : chip_ok, nmi_edge);
    end
  end

  // ==========================================================
  // registered outputs
  logic halt_exit;
  logic sleep_exit;
  assign halt_exit = (mode_reg == lpm_pkg::LPM_HALT) & wake_halt;
  assign sleep_exit = (mode_reg == lpm_pkg::LPM_WAKE) & (wake_cnt_reg == RESTART_LAST);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_resume <= 1'b0;
      o_take_irq <= 1'b0;
    end else begin
      o_resume <= halt_exit | sleep_exit;
      o_take_irq <= halt_exit ? (nmi_edge | i_global_irq_enable_flag)
                              : (sleep_exit & wake_irq_reg);
    end
  end

  // cause and address are refreshed every cycle; a halt cause shows for one cycle, then the latched sleep cause returns
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_sel <= 3'h7;
      o_return_addr <= 20'h00000;
    end else begin
      o_irq_sel <= halt_exit ? pick_src(ext_ok, chip_ok, nmi_edge) : wake_src_reg;
      o_return_addr <= ret_reg;
    end
  end

  // ==========================================================
  // low-power decode shared by the gates and the pins
  function automatic logic mode_gated(input lpm_pkg::lpm_mode_t m);
    return (m == lpm_pkg::LPM_SLEEP) || (m == lpm_pkg::LPM_SSTOP);
  endfunction

  function automatic logic mode_low(input lpm_pkg::lpm_mode_t m);
    return mode_gated(m) || (m == lpm_pkg::LPM_HALT);
  endfunction

  // core, dma and refresh gates and the pin states follow the next mode so they line up with it
  logic low_halt;
  logic low_gated;
  logic low_any;
  assign low_halt = (mode_next == lpm_pkg::LPM_HALT);
  assign low_gated = mode_gated(mode_next);
  assign low_any = mode_low(mode_next);

  // o_mode is the registered copy of the next state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mode <= 3'h0;
    end else begin
      o_mode <= mode_next;
    end
  end

  // core, dma and refresh share one gate; the waking state already runs them
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cpu_clk_en <= 1'b1;
      o_dma_clk_en <= 1'b1;
      o_refresh_en <= 1'b1;
    end else begin
      o_cpu_clk_en <= ~low_gated;
      o_dma_clk_en <= ~low_gated;
      o_refresh_en <= ~low_gated;
    end
  end

  // peripherals follow the stop bit in every mode, so sleep keeps them running
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_periph_clk_en <= 1'b1;
    end else begin
      o_periph_clk_en <= ~i_peripheral_stop_bit;
    end
  end

  // clock output never stops, so external logic keeps its timing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_clk_out_en <= 1'b1;
    end else begin
      o_clk_out_en <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_refetch <= 1'b0;
    end else begin
      o_refetch <= low_halt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_halt_indicator_n <= 1'b1;
      o_bus_status_output <= 1'b1;
      o_fetch_cycle_indicator_n <= 1'b1;
    end else begin
      o_halt_indicator_n <= ~low_any;
      // status low in halt, held high in sleep whether or not the bus is granted away
      o_bus_status_output <= ~low_halt;
      o_fetch_cycle_indicator_n <= ~low_halt;
    end
  end

  // a granted bus belongs to the external master, so hands off
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_force_bus_high <= 1'b0;
      o_addr_idle <= 20'hfffff;
    end else begin
      o_force_bus_high <= low_gated & ~i_bus_granted;
      o_addr_idle <= 20'hfffff;
    end
  end
endmodule

// File: src/lpm_pkg.sv
// constants for the low-power operating mode controller
// assumes one 200 MHz system clock and a synchronous active-high reset
package lpm_pkg;
  // ==========================================================
  // mode encoding
  typedef enum logic [2:0] {
    LPM_NORMAL = 3'h0,
    LPM_HALT   = 3'h1,
    LPM_SLEEP  = 3'h2,
    LPM_SSTOP  = 3'h3,
    LPM_WAKE   = 3'h4
  } lpm_mode_t;

  // ==========================================================
  // control register bit positions used for the sleep gate
  localparam int CCR_BIT_A = 3;
  localparam int CCR_BIT_B = 6;
  localparam int CCR_W = 8;
  localparam int ADDR_W = 20;

  // ==========================================================
  // wake-up restart time, in tenths of a system clock
  localparam int RESTART_TENTHS = 15;
  localparam int RESTART_CYC = (RESTART_TENTHS + 9) / 10;
  localparam logic [1:0] RESTART_CYC_W = 2'(RESTART_CYC);

  // irq vector layout: [0..2] external maskable, [3] nmi, [4..] on-chip
  localparam int N_EXT = 3;
  localparam int N_ONCHIP = 4;
  localparam int N_SRC = N_EXT + 1 + N_ONCHIP;
  localparam int NMI_IDX = N_EXT;
endpackage

// File: src/lpm_sync.sv
// two-flop synchroniser bank for asynchronous pin inputs
// assumes the inputs are levels, not pulses shorter than a clock
`timescale 1ns/1ps
module lpm_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // pins
  input wire logic [WIDTH-1:0] i_async,
  // synchronised
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second; reset value is the idle high level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= '1;
      o_sync <= '1;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// File: verif/lpm_irq_src.sv
// far-side model: external interrupt pins of the mode controller
// assumes the bench raises requests as levels; pins idle high, low while asserted
`timescale 1ns/1ps
module lpm_irq_src (
  // requests: [0..2] external maskable, [3] non-maskable
  input wire logic [3:0] i_req,
  // pins
  output logic o_ext_irq_zero_n,
  output logic o_ext_irq_one_n,
  output logic o_ext_irq_two_n,
  output logic o_nmi_n
);
  // pins are driven as the inverse of each request, so a released request reads high
  assign o_ext_irq_zero_n = ~i_req[0];
  assign o_ext_irq_one_n = ~i_req[1];
  assign o_ext_irq_two_n = ~i_req[2];
  assign o_nmi_n = ~i_req[3];
endmodule

// File: verif/lpm_ctrl_chk.sv
// checker for the mode controller outputs
// assumes it is bound to lpm_ctrl and sees only its ports
`timescale 1ns/1ps
module lpm_ctrl_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // controls
  input wire logic i_halt_exec,
  input wire logic i_sleep_exec,
  input wire logic i_peripheral_stop_bit,
  input wire logic [lpm_pkg::CCR_W-1:0] i_cpu_control_register,
  input wire logic i_bus_granted,
  // outputs watched
  input wire logic [2:0] o_mode,
  input wire logic o_cpu_clk_en,
  input wire logic o_dma_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_refresh_en,
  input wire logic o_clk_out_en,
  input wire logic o_refetch,
  input wire logic o_halt_indicator_n,
  input wire logic o_bus_status_output,
  input wire logic o_fetch_cycle_indicator_n,
  input wire logic o_force_bus_high,
  input wire logic o_resume,
  input wire logic o_take_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic slp;
  logic ccr_clr;
  assign slp = o_mode == 3'h0 && i_sleep_exec && !i_halt_exec;
  assign ccr_clr = !i_cpu_control_register[3] && !i_cpu_control_register[6];
  // ==========================================================
  // assertions
  chk_normal_pin_high: assert property (o_mode == 3'h0 |-> o_halt_indicator_n)
    else $error("halt indicator low in normal mode");
  chk_halt_pins_low: assert property (o_mode == 3'h0 && i_halt_exec |=> o_mode == 3'h1
    && o_refetch && !o_halt_indicator_n && !o_bus_status_output && !o_fetch_cycle_indicator_n)
    else $error("halt entry pins wrong");
  chk_halt_keeps_run: assert property (o_mode == 3'h1 |-> o_dma_clk_en && o_refresh_en
    && o_clk_out_en && o_cpu_clk_en) else $error("clock gated in halt");
  chk_sleep_entry: assert property (slp && !i_peripheral_stop_bit && ccr_clr
    |=> o_mode == 3'h2) else $error("sleep not entered");
  chk_ccr_blocks: assert property (slp && !i_peripheral_stop_bit && !ccr_clr
    |=> o_mode == 3'h0) else $error("sleep entered with control bits set");
  chk_sleep_gates: assert property (o_mode inside {3'h2, 3'h3} |-> !o_cpu_clk_en
    && !o_dma_clk_en && !o_refresh_en && o_clk_out_en && !o_halt_indicator_n)
    else $error("sleep gating wrong");
  chk_bus_held_high: assert property (o_mode == 3'h2 && $past(o_mode) == 3'h2
    && !$past(i_bus_granted) |-> o_force_bus_high) else $error("bus not held high");
  chk_sysstop_entry: assert property (slp && i_peripheral_stop_bit |=> o_mode == 3'h3)
    else $error("system stop not entered");
  chk_restart_time: assert property ($rose(o_mode == 3'h4) |=> o_mode == 3'h4
    ##1 (o_resume && o_mode == 3'h0)) else $error("restart time wrong");
  chk_periph_gate: assert property (!$past(i_rst) |-> o_periph_clk_en
    == !$past(i_peripheral_stop_bit)) else $error("peripheral clock wrong");
  chk_reset_normal: assert property (disable iff (1'b0) i_rst |=> o_mode == 3'h0)
    else $error("reset did not restore normal mode");
  cov_halt: cover property (o_mode == 3'h1);
  cov_sleep: cover property (o_mode == 3'h2);
  cov_sysstop: cover property (o_mode == 3'h3);
  cov_take: cover property (o_resume && o_take_irq);
endmodule

// File: verif/test_lpm_ctrl.sv
// self-checking bench for the mode controller with an interrupt pin model
// assumes a 200 MHz clock; inputs change at the falling edge
`timescale 1ns/1ps
module test_lpm_ctrl;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_halt_exec = 1'b0, i_sleep_exec = 1'b0, i_peripheral_stop_bit = 1'b0;
  logic i_global_irq_enable_flag = 1'b1, i_bus_granted = 1'b0;
  logic [19:0] i_next_pc = 20'h0;
  logic [7:0] i_cpu_control_register = 8'h0;
  logic [2:0] i_ext_irq_en = 3'h7;
  logic [3:0] i_onchip_irq = 4'h0, i_onchip_irq_en = 4'hf, req = 4'h0;
  logic nmi_n, e0_n, e1_n, e2_n, cpu_en, dma_en, per_en, ref_en, clko, refetch;
  logic halt_n, stat, fetch_n, force_hi, resume, take;
  logic [2:0] o_mode, sel;
  logic [19:0] addr_idle, ret;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  always #2.5 i_clk = ~i_clk;
  lpm_irq_src i_lpm_irq_src (.i_req(req), .o_ext_irq_zero_n(e0_n), .o_ext_irq_one_n(e1_n),
    .o_ext_irq_two_n(e2_n), .o_nmi_n(nmi_n));
  lpm_ctrl i_lpm_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_halt_exec(i_halt_exec),
    .i_sleep_exec(i_sleep_exec), .i_next_pc(i_next_pc),
    .i_peripheral_stop_bit(i_peripheral_stop_bit), .i_cpu_control_register(i_cpu_control_register),
    .i_global_irq_enable_flag(i_global_irq_enable_flag), .i_nmi_n(nmi_n),
    .i_ext_irq_zero_n(e0_n), .i_ext_irq_one_n(e1_n), .i_ext_irq_two_n(e2_n),
    .i_ext_irq_en(i_ext_irq_en), .i_onchip_irq(i_onchip_irq), .i_onchip_irq_en(i_onchip_irq_en),
    .i_bus_granted(i_bus_granted), .o_mode(o_mode), .o_cpu_clk_en(cpu_en), .o_dma_clk_en(dma_en),
    .o_periph_clk_en(per_en), .o_refresh_en(ref_en), .o_clk_out_en(clko), .o_refetch(refetch),
    .o_halt_indicator_n(halt_n), .o_bus_status_output(stat), .o_fetch_cycle_indicator_n(fetch_n),
    .o_force_bus_high(force_hi), .o_addr_idle(addr_idle), .o_resume(resume), .o_take_irq(take),
    .o_irq_sel(sel), .o_return_addr(ret));
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic strobe(input logic slp, input logic [19:0] pc);
    i_next_pc = pc;
    i_sleep_exec = slp;
    i_halt_exec = !slp;
    tick(1);
    i_sleep_exec = 1'b0;
    i_halt_exec = 1'b0;
  endtask
  // waits for the exit strobe; a sleep exit passes through the waking state first
  task automatic wake(input logic [3:0] r, input logic tk, input logic [2:0] s,
                      input logic [19:0] pc);
    int n;
    n = 0;
    req = r;
    while (resume !== 1'b1 && o_mode !== 3'h4 && n < 20) begin
      tick(1);
      n++;
    end
    if (o_mode === 3'h4) tick(2);
    chk("resume", {resume, o_mode}, {1'b1, 3'h0});
    chk("take", take, tk);
    chk("sel", sel, s);
    chk("ret", ret, pc);
    req = 4'h0;
    i_onchip_irq = 4'h0;
    tick(3);
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ==========================================================
  // tests
  initial begin
    tick(2);
    i_rst = 1'b0;
    chk("reset", {o_mode, halt_n, sel}, {3'h0, 1'b1, 3'h7});
    i_ext_irq_en = 3'h5;
    strobe(1'b0, 20'h12345);
    chk("halt pins", {o_mode, halt_n, stat, fetch_n, refetch}, {3'h1, 4'h1});
    chk("halt run", {cpu_en, dma_en, ref_en, clko, per_en}, 5'h1f);
    req = 4'h2;
    tick(8);
    chk("halt held", o_mode, 3'h1);
    wake(4'h1, 1'b1, 3'h0, 20'h12345);
    strobe(1'b0, 20'h00777);
    i_onchip_irq = 4'h2;
    wake(4'h0, 1'b1, 3'h4, 20'h00777);
    foreach (i_onchip_irq_en[k]) if (k < 2) begin
      i_cpu_control_register = k ? 8'h40 : 8'h08;
      strobe(1'b1, 20'h0);
      chk("ccr block", o_mode, 3'h0);
    end
    i_cpu_control_register = 8'h0;
    i_ext_irq_en = 3'h3;
    i_global_irq_enable_flag = 1'b0;
    strobe(1'b1, 20'h0abcd);
    tick(1);
    chk("sleep", {o_mode, cpu_en, dma_en, ref_en, clko, halt_n, force_hi}, 9'h085);
    chk("addr", addr_idle, 20'hfffff);
    chk("periph", per_en, 1'b1);
    i_bus_granted = 1'b1;
    tick(2);
    chk("granted", force_hi, 1'b0);
    i_bus_granted = 1'b0;
    req = 4'h4;
    tick(8);
    chk("disabled", o_mode, 3'h2);
    i_ext_irq_en = 3'h7;
    wake(4'h4, 1'b0, 3'h2, 20'h0abcd);
    i_global_irq_enable_flag = 1'b1;
    strobe(1'b1, 20'hfffff);
    wake(4'h8, 1'b1, 3'h3, 20'hfffff);
    i_peripheral_stop_bit = 1'b1;
    tick(2);
    chk("io stop", {o_mode, per_en}, 4'h0);
    strobe(1'b1, 20'h00010);
    i_onchip_irq = 4'h1;
    tick(8);
    chk("sysstop", {o_mode, per_en}, 4'h6);
    wake(4'h1, 1'b1, 3'h0, 20'h00010);
    i_peripheral_stop_bit = 1'b0;
    tick(2);
    chk("io run", per_en, 1'b1);
    strobe(1'b1, 20'h0);
    i_rst = 1'b1;
    tick(1);
    i_rst = 1'b0;
    chk("reset sleep", {o_mode, halt_n}, 4'h1);
    final_report();
  end
endmodule
bind lpm_ctrl lpm_ctrl_chk i_lpm_ctrl_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_halt_exec(i_halt_exec), .i_sleep_exec(i_sleep_exec),
  .i_peripheral_stop_bit(i_peripheral_stop_bit), .i_cpu_control_register(i_cpu_control_register),
  .i_bus_granted(i_bus_granted), .o_mode(o_mode), .o_cpu_clk_en(o_cpu_clk_en),
  .o_dma_clk_en(o_dma_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_refresh_en(o_refresh_en),
  .o_clk_out_en(o_clk_out_en), .o_refetch(o_refetch), .o_halt_indicator_n(o_halt_indicator_n),
  .o_bus_status_output(o_bus_status_output), .o_fetch_cycle_indicator_n(o_fetch_cycle_indicator_n),
  .o_force_bus_high(o_force_bus_high), .o_resume(o_resume), .o_take_irq(o_take_irq));
